// *** core/bmr_defs.svh ***
// offsets, field positions, reset values and sizes of the board register bank
`ifndef BMR_DEFS_SVH
`define BMR_DEFS_SVH
`define BMR_OFF_STATUS      5'h01
`define BMR_OFF_SERIAL_CMD  5'h0d
`define BMR_OFF_TRIG_CMD    5'h0f
`define BMR_OFF_ADC_FIFO    5'h1c
`define BMR_SER_CLK_BIT     0
`define BMR_SER_DATA_BIT    1
`define BMR_SER_CS_BIT      2
`define BMR_SER_LOAD_LSB    3
`define BMR_TRIG_SEL_BIT    7
`define BMR_STAT_PROM_BIT   0
`define BMR_CMD_RESET       8'h00
`define BMR_SER_WRITE_MASK  8'h3f
`define BMR_TRIG_WRITE_MASK 8'h80
`define BMR_FIFO_DEPTH      8
`define BMR_ADC_BITS        12
`define BMR_WORD_BITS       16
`endif

// *** core/bmr_pkg.sv ***
// types shared by the board register bank
package bmr_pkg;
    typedef enum logic
    {
        BMR_BIPOLAR,
        BMR_UNIPOLAR
    } bmr_polarity_e;
    typedef logic [15:0] bmr_word_t;
    typedef enum logic [1:0]
    {
        BMR_SIZE_NONE,
        BMR_SIZE_BYTE,
        BMR_SIZE_WORD
    } bmr_size_e;
endpackage

// *** core/bmr_fifo.sv ***
// synchronous FIFO holding conversion results on their way to the host
`timescale 1ns/1ps
module bmr_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign count_o     = cnt_q;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** core/bmr_result_fmt.sv ***
// formats one raw converter code as straight binary or two's complement
`timescale 1ns/1ps
module bmr_result_fmt
    import bmr_pkg::*;
#(
    parameter int ADC_BITS = 12
)
(
    input  wire logic [ADC_BITS-1:0] raw_i,
    input  wire logic                unipolar_i,
    output bmr_word_t                word_o
);
    // bipolar codes arrive offset binary; flipping the msb gives two's compl.
    logic [ADC_BITS-1:0] twos;
    assign twos = {~raw_i[ADC_BITS-1], raw_i[ADC_BITS-2:0]};
    assign word_o = unipolar_i
        ? bmr_word_t'({{(16-ADC_BITS){1'b0}}, raw_i})
        : bmr_word_t'({{(16-ADC_BITS){twos[ADC_BITS-1]}}, twos});
endmodule

// *** core/bmr_regs.sv ***
// board misc command, status and conversion result FIFO register bank
`timescale 1ns/1ps
`include "bmr_defs.svh"
module bmr_regs
    import bmr_pkg::*;
#(
    parameter int ADC_BITS = `BMR_ADC_BITS,
    parameter int DEPTH    = `BMR_FIFO_DEPTH
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [4:0]          addr_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    input  wire logic                word_i,
    input  wire logic [15:0]         wdata_i,
    output logic      [15:0]         rdata_o,
    output logic                     rvalid_o,
    input  wire logic [ADC_BITS-1:0] conv_data_i,
    input  wire logic                conv_done_i,
    input  wire logic                conv_unipolar_i,
    input  wire logic                conv_ghost_i,
    output logic                     conv_ready_o,
    input  wire logic                cal_memory_serial_out_i,
    output logic                     serial_clock_bit_o,
    output logic                     serial_data_bit_o,
    output logic                     cal_memory_select_o,
    output logic                     cal_dac_set1_load_o,
    output logic                     cal_dac_set2_load_o,
    output logic                     cal_dac_set3_load_o,
    output logic                     trig_sel_amp_o,
    output logic                     fifo_empty_o,
    output logic                     fifo_half_o,
    output logic                     fifo_full_o
);
    localparam int CW = $clog2(DEPTH) + 1;

    // =====================================================
    // access decode
    // =====================================================
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off,
                                 input logic w, input logic want_word);
        hit = (a == off) && (w == want_word);
    endfunction

    logic [7:0]  ser_q;
    logic [7:0]  trig_q;
    bmr_word_t   fmt_word;
    bmr_word_t   fifo_head;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        pop;
    logic        push_valid;
    logic [CW-1:0] count;
    logic [CW-1:0] count_next;

    logic ser_wr;
    logic trig_wr;
    logic stat_rd;
    logic fifo_rd;
    assign ser_wr  = wr_i && hit(addr_i, `BMR_OFF_SERIAL_CMD, word_i, 1'b0);
    assign trig_wr = wr_i && hit(addr_i, `BMR_OFF_TRIG_CMD, word_i, 1'b0);
    assign stat_rd = rd_i && hit(addr_i, `BMR_OFF_STATUS, word_i, 1'b0);
    assign fifo_rd = rd_i && hit(addr_i, `BMR_OFF_ADC_FIFO, word_i, 1'b1);

    // =====================================================
    // command registers
    // =====================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ser_q <= `BMR_CMD_RESET;
        end
        else if (ser_wr)
        begin
            ser_q <= wdata_i[7:0] & `BMR_SER_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_q <= `BMR_CMD_RESET;
        end
        else if (trig_wr)
        begin
            trig_q <= wdata_i[7:0] & `BMR_TRIG_WRITE_MASK;
        end
    end

    // register bits are the pins, so software edges pass straight through
    // clock pin
    assign serial_clock_bit_o  = ser_q[`BMR_SER_CLK_BIT];
    assign serial_data_bit_o   = ser_q[`BMR_SER_DATA_BIT];
    assign cal_memory_select_o = ser_q[`BMR_SER_CS_BIT];
    assign cal_dac_set1_load_o = ser_q[`BMR_SER_LOAD_LSB];
    assign cal_dac_set2_load_o = ser_q[`BMR_SER_LOAD_LSB + 1];
    assign cal_dac_set3_load_o = ser_q[`BMR_SER_LOAD_LSB + 2];
    assign trig_sel_amp_o      = trig_q[`BMR_TRIG_SEL_BIT];

    // =====================================================
    // conversion result path
    // =====================================================
    // per-conversion polarity
    bmr_result_fmt #(.ADC_BITS(ADC_BITS)) u_fmt
    (
        .raw_i      (conv_data_i),
        .unipolar_i (conv_unipolar_i),
        .word_o     (fmt_word)
    );

    assign push_valid   = conv_done_i && !conv_ghost_i;
    assign count_next   = count + CW'(push_valid && fifo_in_ready) - CW'(pop);
    assign pop          = fifo_rd && fifo_out_valid;

    bmr_fifo #(.WIDTH(`BMR_WORD_BITS), .DEPTH(DEPTH)) u_fifo
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (fmt_word),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_head),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .count_o     (count)
    );

    // =====================================================
    // status flags
    // =====================================================
    // flags registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fifo_empty_o <= 1'b1;
            fifo_half_o  <= 1'b0;
            fifo_full_o  <= 1'b0;
        end
        else
        begin
            fifo_empty_o <= (count == '0);
            fifo_half_o  <= (count >= CW'(DEPTH / 2));
            fifo_full_o  <= (count == CW'(DEPTH));
        end
    end

    // taken from the next occupancy so the flop never lags a push or pop
    // ready registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_ready_o <= 1'b1;
        end
        else
        begin
            conv_ready_o <= (count_next != CW'(DEPTH));
        end
    end

    // =====================================================
    // read data
    // =====================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_o  <= '0;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= rd_i;
            if (stat_rd)
            begin
                rdata_o <= {15'h0000, cal_memory_serial_out_i};
            end
            else if (pop)
            begin
                rdata_o <= fifo_head;
            end
            else
            begin
                // unmapped, wrong width or empty FIFO reads zero
                rdata_o <= '0;
            end
        end
    end

    // =====================================================
    // checks
    // =====================================================
    a_cmd_reset_clear:
    assert property (@(posedge clk_i) rst_i |=> (ser_q == 8'h00
                     && trig_q == 8'h00))
        else $error("command registers not cleared by reset");

    a_cs_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> cal_memory_select_o == $past(wdata_i[2]))
        else $error("chip select does not follow bit 2");

    a_clock_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> serial_clock_bit_o == $past(wdata_i[0]))
        else $error("serial clock does not follow bit 0");

    a_load_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> cal_dac_set3_load_o == $past(wdata_i[5]))
        else $error("third load strobe does not follow bit 5");

    a_trig_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     trig_wr |=> trig_sel_amp_o == $past(wdata_i[7]))
        else $error("trigger select does not follow bit 7");

    a_status_bit_read:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     stat_rd |=> rdata_o == {15'h0000,
                     $past(cal_memory_serial_out_i)})
        else $error("status read lost memory output");

    a_pop_returns_head:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     pop |=> rdata_o == $past(fifo_head)
                     && count == $past(count) - CW'(1)
                        + CW'($past(push_valid && fifo_in_ready)))
        else $error("result read did not pop head");

    a_ghost_not_stored:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     (conv_done_i && conv_ghost_i && !pop)
                     |=> count == $past(count))
        else $error("ghost result entered FIFO");

    a_empty_read_safe:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     (fifo_rd && count == '0 && !push_valid)
                     |=> count == '0)
        else $error("empty read disturbed FIFO");

    a_empty_flag_set:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     count == '0 |=> fifo_empty_o)
        else $error("empty flag missing");

    a_half_flag_set:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     count >= CW'(DEPTH / 2) |=> fifo_half_o)
        else $error("half flag missing");

    a_ready_tracks_space:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     conv_ready_o == (count != CW'(DEPTH)))
        else $error("conversion ready disagrees with occupancy");

    a_load1_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> cal_dac_set1_load_o == $past(wdata_i[3]))
        else $error("first load strobe does not follow bit 3");

    a_load2_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> cal_dac_set2_load_o == $past(wdata_i[4]))
        else $error("second load strobe does not follow bit 4");

    a_data_follows_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     ser_wr |=> serial_data_bit_o == $past(wdata_i[1]))
        else $error("serial data does not follow bit 1");

    a_bipolar_sign:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     (!conv_unipolar_i && !conv_data_i[ADC_BITS-1])
                     |-> fmt_word[15])
        else $error("bipolar low code not negative");
endmodule

// *** testbench/bmr_host_model.sv ***
// host model issuing byte and word accesses on the register bus
`timescale 1ns/1ps
module bmr_host_model
(
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic      [4:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic             word_o,
    output logic      [15:0] wdata_o
);
    initial
    begin
        addr_o  = 5'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        word_o  = 1'b0;
        wdata_o = 16'h0000;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        word_o  <= 1'b0;
        wdata_o <= {8'h00, d};
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // released data no longer shows the last value
        wdata_o <= ~{8'h00, d};
    endtask
    task automatic rd(input logic [4:0] a, input logic w,
                      output logic [15:0] q, output logic v);
        @(posedge clk_i);
        addr_o <= a;
        word_o <= w;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        q = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// *** testbench/bmr_regs_bench.sv ***
// self-checking bench for the board register bank
`timescale 1ns/1ps
`include "bmr_defs.svh"
module bmr_regs_bench
    import bmr_pkg::*;
;
    logic        clk_i, rst_i, done, unip, ghost, prom;
    logic [11:0] cdata;
    logic [4:0]  addr;
    logic        wr, rd, word, rvalid, cready, sclk, sdat, cs;
    logic        ld1, ld2, ld3, trig, empty, half, full;
    logic [15:0] wdata, rdata;
    logic [5:0]  ser;
    int          errors;
    int          n_compared;
    assign ser = {ld3, ld2, ld1, cs, sdat, sclk};
    bmr_host_model host (.clk_i(clk_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .word_o(word), .wdata_o(wdata));
    bmr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
        .wr_i(wr), .rd_i(rd), .word_i(word), .wdata_i(wdata),
        .rdata_o(rdata), .rvalid_o(rvalid), .conv_data_i(cdata),
        .conv_done_i(done), .conv_unipolar_i(unip),
        .conv_ghost_i(ghost), .conv_ready_o(cready),
        .cal_memory_serial_out_i(prom), .serial_clock_bit_o(sclk),
        .serial_data_bit_o(sdat), .cal_memory_select_o(cs),
        .cal_dac_set1_load_o(ld1), .cal_dac_set2_load_o(ld2),
        .cal_dac_set3_load_o(ld3), .trig_sel_amp_o(trig),
        .fifo_empty_o(empty), .fifo_half_o(half), .fifo_full_o(full));
    // ====================================================
    // helpers
    task automatic chk(input string name, input bmr_word_t exp,
                       input bmr_word_t got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp,
                     got);
        end
    endtask
    // expected host word from a raw code, worked out independently
    function automatic bmr_word_t fmt(input logic [11:0] d,
                                      input logic u);
        return u ? {4'h0, d} : {{5{~d[11]}}, d[10:0]};
    endfunction
    task automatic push(input logic [11:0] d, input logic u,
                        input logic g);
        @(posedge clk_i);
        cdata <= d;
        unip  <= u;
        ghost <= g;
        done  <= 1'b1;
        @(posedge clk_i);
        done  <= 1'b0;
        cdata <= ~d;
        // flags lag the count by one edge
        @(posedge clk_i);
        #1;
    endtask
    // ====================================================
    // scenarios
    task automatic t_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("command outputs", 16'h0000, {9'h000, trig, ser});
        chk("flags", 16'h0001, {13'h0000, full, half, empty});
    endtask
    task automatic t_commands();
        for (int i = 0; i < 6; i++)
        begin
            host.wr(`BMR_OFF_SERIAL_CMD, 8'h01 << i);
            #1;
            chk("serial", 16'h0001 << i, {10'h000, ser});
        end
        host.wr(`BMR_OFF_SERIAL_CMD, 8'h03);
        #1;
        chk("data with clock", 16'h0003, {10'h000, ser});
        host.wr(`BMR_OFF_TRIG_CMD, 8'h80);
        #1;
        chk("trigger select", 16'h0043, {9'h000, trig, ser});
        host.wr(`BMR_OFF_TRIG_CMD, 8'h00);
        #1;
        chk("trigger select", 16'h0003, {9'h000, trig, ser});
        host.wr(`BMR_OFF_TRIG_CMD, 8'h80);
        t_reset();
    endtask
    task automatic t_status();
        bmr_word_t q;
        logic      v;
        for (int i = 1; i >= 0; i--)
        begin
            prom <= i[0];
            host.rd(`BMR_OFF_STATUS, 1'b0, q, v);
            chk("status bit", 16'(i), {15'h0000, q[0]});
        end
        chk("read valid", 16'h0001, {15'h0000, v});
        host.rd(5'h03, 1'b0, q, v);
        chk("unmapped read", 16'h0000, q);
    endtask
    task automatic t_fifo();
        logic [11:0] tab [8];
        bmr_word_t   exp [$];
        bmr_word_t   f;
        bmr_word_t   q;
        logic        v;
        tab = '{12'hfff, 12'h000, 12'h000, 12'hfff, 12'h800, 12'h7ff,
                12'h123, 12'habc};
        push(12'h555, 1'b1, 1'b1);
        chk("ghost dropped", 16'h0001, {15'h0000, empty});
        for (int n = 0; n < 8; n++)
        begin
            push(tab[n], n[0], 1'b0);
            exp.push_back(fmt(tab[n], n[0]));
            f = {13'h0000, n == 7, n >= 3, 1'b0};
            chk("flags", f, {13'h0000, full, half, empty});
        end
        chk("ready when full", 16'h0000, {15'h0000, cready});
        push(12'h321, 1'b1, 1'b0);
        host.rd(`BMR_OFF_ADC_FIFO, 1'b0, q, v);
        chk("byte result read", 16'h0000, q);
        for (int n = 0; n < 8; n++)
        begin
            host.rd(`BMR_OFF_ADC_FIFO, 1'b1, q, v);
            chk("result", exp[n], q);
        end
        @(posedge clk_i);
        #1;
        chk("drained", 16'h0001, {13'h0000, full, half, empty});
        chk("ready after drain", 16'h0001, {15'h0000, cready});
        host.rd(`BMR_OFF_ADC_FIFO, 1'b1, q, v);
        @(posedge clk_i);
        #1;
        chk("empty read", 16'h0001, {15'h0000, empty});
        chk("empty read data", 16'h0000, q);
        push(12'h7ff, 1'b1, 1'b0);
        host.rd(`BMR_OFF_ADC_FIFO, 1'b1, q, v);
        chk("after empty read", 16'h07ff, q);
    endtask
    // ====================================================
    // run control
    task automatic test_done();
        $display("errors %0d, compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        #800000;
        errors++;
        test_done();
    end
    initial
    begin
        errors     = 0;
        n_compared = 0;
        rst_i      = 1'b1;
        done       = 1'b0;
        unip       = 1'b0;
        ghost      = 1'b0;
        prom       = 1'b0;
        cdata      = 12'h000;
        t_reset();
        t_commands();
        t_status();
        t_fifo();
        test_done();
    end
endmodule
